//--- src/pmc_pkg.sv
// constants, mode codes and timing for the phy power mode controller
package pmc_pkg;

   // operating mode codes, shown on the power mode field
   typedef enum logic [3:0] {
      PMC_POWER_OFF = 4'h0,
      PMC_RESET     = 4'h1,
      PMC_DISABLE   = 4'h2,
      PMC_NORMAL    = 4'h3,
      PMC_SILENT    = 4'h9,
      PMC_SLEEP     = 4'ha,
      PMC_SLEEP_REQ = 4'hb,
      PMC_STANDBY   = 4'hc
   } pmc_mode_t;

   // management register holding the power mode field
   localparam logic [4:0] PMC_MODE_REG_ADDR = 5'h11;

   // clock modes that may keep the crystal alive in sleep
   localparam logic [1:0] PMC_CLK_MODE_A = 2'h0;
   localparam logic [1:0] PMC_CLK_MODE_B = 2'h1;

   // core clock
   localparam int PMC_CLK_PERIOD_NS = 50;

   // timeouts as plain defaults, in nanoseconds
   localparam int PMC_T_REQ_SLEEP_NS = 16000000;
   localparam int PMC_T_ACK_SLEEP_NS = 8000000;
   localparam int PMC_T_AUTO_PD_NS = 80000000;
   localparam int PMC_T_RST_DET_NS = 20000;

   // least times round up to whole cycles, never below one
   function automatic int pmc_cycles(input int t_ns);
      int c;
      c = (t_ns + PMC_CLK_PERIOD_NS - 1) / PMC_CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int PMC_REQ_SLEEP_CYC = pmc_cycles(PMC_T_REQ_SLEEP_NS);
   localparam int PMC_ACK_SLEEP_CYC = pmc_cycles(PMC_T_ACK_SLEEP_NS);
   localparam int PMC_AUTO_PD_CYC = pmc_cycles(PMC_T_AUTO_PD_NS);
   localparam int PMC_RST_DET_CYC = pmc_cycles(PMC_T_RST_DET_NS);

   localparam int PMC_TIMER_WIDTH = 24;

endpackage

//--- src/pmc_timer.sv
// elapsed-time counter that flags once a limit is reached
`timescale 1ns/100ps
module pmc_timer #(
   parameter int WIDTH = 24,
   parameter int LIMIT = 400
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic run_i,
   output logic expired_o
);
   localparam logic [WIDTH-1:0] LIMIT_V = WIDTH'(LIMIT);

   logic [WIDTH-1:0] count;
   wire at_limit = (count >= LIMIT_V);

   generate
      if (LIMIT < 1 || LIMIT >= (2 ** WIDTH) - 1)
      begin : g_bad
         $error("pmc_timer limit does not fit the counter");
      end
   endgenerate

   // restart whenever run drops; saturate at the limit
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
         count <= '0;
      else if (ce_i)
      begin
         if (!run_i)
            count <= '0;
         else if (!at_limit)
            count <= count + WIDTH'(1);
      end
   end

   assign expired_o = at_limit;
endmodule

//--- src/pmc_block_ctrl.sv
// per-mode enables of pins, crystal, regulator and inhibit
`timescale 1ns/100ps
module pmc_block_ctrl (
   input wire logic [3:0] mode_i,
   input wire logic clk_hold_i,
   input wire logic [1:0] clk_mode_i,
   input wire logic core_regulator_select_i,
   input wire logic disable_inhibit_behavior_i,
   output logic mii_active_o,
   output logic mii_rx_force_low_o,
   output logic mii_pulldown_o,
   output logic crystal_enable_o,
   output logic internal_ldo_enable_o,
   output logic inhibit_o
);
   wire in_standby = (mode_i == pmc_pkg::PMC_STANDBY);
   wire in_sleep = (mode_i == pmc_pkg::PMC_SLEEP);
   wire in_disable = (mode_i == pmc_pkg::PMC_DISABLE);
   wire in_off = (mode_i == pmc_pkg::PMC_POWER_OFF);
   wire link_up = (mode_i == pmc_pkg::PMC_NORMAL) || (mode_i == pmc_pkg::PMC_SLEEP_REQ)
      || (mode_i == pmc_pkg::PMC_SILENT);
   wire clk_mode_keeps = (clk_mode_i == pmc_pkg::PMC_CLK_MODE_A)
      || (clk_mode_i == pmc_pkg::PMC_CLK_MODE_B);

   assign mii_active_o = link_up;
   assign mii_rx_force_low_o = in_standby;
   assign mii_pulldown_o = in_standby;
   assign crystal_enable_o = link_up || (in_sleep && clk_hold_i && clk_mode_keeps);
   assign internal_ldo_enable_o = !core_regulator_select_i
      && (link_up || in_standby || (mode_i == pmc_pkg::PMC_RESET));
   assign inhibit_o = in_disable ? disable_inhibit_behavior_i : !(in_sleep || in_off);
endmodule

//--- src/pmc_mode_ctrl.sv
// operating mode controller of a single-pair ethernet phy
// Function
// - standby drives rx data, rx error, rx valid low; other mii pins pulled down.
// - sleep allows only mode register access, and only with io supply present.
// - crystal stops in sleep unless clock hold set and clock mode 00 or 01.
// - regulator select low uses internal core supply; high expects external supply.
// - in disable, inhibit output follows the disable inhibit configuration bit.
// - priority: power, io undervoltage, reset pin, enable pin, faults, commands/wake.
// - silent returns to normal when the sleep request timer expires.
// - host writes 1011 in normal; device moves to sleep request.
// - auto power-down with no frames beyond timeout moves normal to sleep request.
// - enabled codes, sleep code received and active, time met: enter sleep request.
// - no activity means receive valid false and transmit enable low.
// - host writes 0011 in sleep request; device returns to normal.
// - wake request (forwarded flag or line code) returns sleep request to normal.
// - data activity with sleep ack 0 returns or keeps the device in normal.
// - with sleep ack 1, return to normal only before ack timer expires.
// - codes disabled: sleep request goes straight to sleep at request timeout.
// - codes enabled: sleep request goes to silent once the sleep code is received, else to normal at request timeout.
// - silent goes to sleep once the line carries no activity.
// - reset pin held low enters reset, except from power-off and sleep; registers default.
`timescale 1ns/100ps
module pmc_mode_ctrl #(
   parameter int REQ_SLEEP_CYC = pmc_pkg::PMC_REQ_SLEEP_CYC,
   parameter int ACK_SLEEP_CYC = pmc_pkg::PMC_ACK_SLEEP_CYC,
   parameter int AUTO_PD_CYC = pmc_pkg::PMC_AUTO_PD_CYC,
   parameter int RST_DET_CYC = pmc_pkg::PMC_RST_DET_CYC
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic power_good_i,
   input wire logic io_undervoltage_i,
   input wire logic rst_pin_n_i,
   input wire logic en_pin_i,
   input wire logic core_fault_i,
   input wire logic mgmt_valid_i,
   input wire logic mgmt_write_i,
   input wire logic [4:0] mgmt_addr_i,
   input wire logic [3:0] mgmt_wdata_i,
   input wire logic autonomous_i,
   input wire logic clk_hold_i,
   input wire logic [1:0] clk_mode_i,
   input wire logic core_regulator_select_i,
   input wire logic disable_inhibit_behavior_i,
   input wire logic auto_powerdown_enable_i,
   input wire logic sleep_wake_code_disable_i,
   input wire logic sleep_code_received_i,
   input wire logic sleep_code_active_i,
   input wire logic forward_to_line_enable_i,
   input wire logic wake_event_flag_i,
   input wire logic wake_request_code_i,
   input wire logic sleep_ack_i,
   input wire logic pcs_rx_dv_i,
   input wire logic tx_en_i,
   input wire logic line_activity_i,
   output logic [3:0] power_mode_o,
   output logic mgmt_grant_o,
   output logic mii_active_o,
   output logic mii_rx_force_low_o,
   output logic mii_pulldown_o,
   output logic crystal_enable_o,
   output logic internal_ldo_enable_o,
   output logic regulator_inhibit_out_o,
   output logic sleep_request_code_o,
   output logic regs_default_o
);
   localparam int TW = pmc_pkg::PMC_TIMER_WIDTH;

   pmc_pkg::pmc_mode_t mode;
   pmc_pkg::pmc_mode_t prev_mode;
   pmc_pkg::pmc_mode_t next_mode;

   logic rst_held;
   logic req_expired;
   logic ack_expired;
   logic pd_expired;
   logic code_expired;

   function automatic logic is_mode(input pmc_pkg::pmc_mode_t m, input pmc_pkg::pmc_mode_t want);
      return m == want;
   endfunction

   // mode flags
   wire in_normal = is_mode(mode, pmc_pkg::PMC_NORMAL);
   wire in_sreq = is_mode(mode, pmc_pkg::PMC_SLEEP_REQ);
   wire in_silent = is_mode(mode, pmc_pkg::PMC_SILENT);
   wire in_sleep = is_mode(mode, pmc_pkg::PMC_SLEEP);
   wire in_off = is_mode(mode, pmc_pkg::PMC_POWER_OFF);
   wire in_reset = is_mode(mode, pmc_pkg::PMC_RESET);
   wire in_disable = is_mode(mode, pmc_pkg::PMC_DISABLE);
   wire settled = (mode == prev_mode);

   wire quiet = !pcs_rx_dv_i && !tx_en_i;
   wire activity = !quiet;

   // sleep narrows management access to the mode register
   wire access_ok = !in_off && !in_reset && !in_disable
      && (!in_sleep || ((mgmt_addr_i == pmc_pkg::PMC_MODE_REG_ADDR) && !io_undervoltage_i));
   wire mode_cmd = mgmt_valid_i && mgmt_write_i && access_ok
      && (mgmt_addr_i == pmc_pkg::PMC_MODE_REG_ADDR);
   wire cmd_sreq = mode_cmd && (mgmt_wdata_i == pmc_pkg::PMC_SLEEP_REQ);
   wire cmd_normal = mode_cmd && (mgmt_wdata_i == pmc_pkg::PMC_NORMAL);
   wire cmd_standby = mode_cmd && (mgmt_wdata_i == pmc_pkg::PMC_STANDBY);

   // higher-priority events; reset and enable pins are dead in sleep
   wire rst_evt = rst_held && !in_sleep && !in_off;
   wire rst_rel = in_reset && rst_pin_n_i;
   wire en_evt = !en_pin_i && !in_sleep && !in_off && !in_reset;
   wire en_rel = in_disable && en_pin_i;
   wire fault_evt = core_fault_i && (in_normal || in_sreq || in_silent);
   wire io_evt = io_undervoltage_i && !in_sleep && !in_off;
   wire low_ok = power_good_i && !io_evt && !rst_evt && !rst_rel && !en_evt && !en_rel
      && !fault_evt && !in_off;

   wire wake_req = (forward_to_line_enable_i && wake_event_flag_i) || wake_request_code_i;
   // ack timer gates returns once it runs out
   wire back_allowed = !sleep_ack_i || !ack_expired;
   wire back_to_normal = back_allowed && (cmd_normal || wake_req || (activity && !sleep_ack_i));
   wire code_path = !sleep_wake_code_disable_i && sleep_code_received_i && sleep_code_active_i;

   // request timer runs in sleep request and silent, restarts on entry to each
   pmc_timer #(.WIDTH(TW), .LIMIT(REQ_SLEEP_CYC)) u_req_timer (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .run_i((in_sreq || in_silent) && settled),
      .expired_o(req_expired)
   );

   // ack timer only while sleep ack is set
   pmc_timer #(.WIDTH(TW), .LIMIT(ACK_SLEEP_CYC)) u_ack_timer (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .run_i(in_sreq && settled && sleep_ack_i),
      .expired_o(ack_expired)
   );

   // auto power-down counts idle time in normal
   pmc_timer #(.WIDTH(TW), .LIMIT(AUTO_PD_CYC)) u_pd_timer (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .run_i(in_normal && auto_powerdown_enable_i && quiet),
      .expired_o(pd_expired)
   );

   // sleep code must persist for the request time
   pmc_timer #(.WIDTH(TW), .LIMIT(REQ_SLEEP_CYC)) u_code_timer (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .run_i(in_normal && code_path),
      .expired_o(code_expired)
   );

   // reset pin must stay low for the detect time
   pmc_timer #(.WIDTH(TW), .LIMIT(RST_DET_CYC)) u_rst_filter (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .run_i(!rst_pin_n_i),
      .expired_o(rst_held)
   );

   always_comb
   begin
      next_mode = mode;
      if (!power_good_i)
         next_mode = pmc_pkg::PMC_POWER_OFF;
      else if (in_off || io_evt)
         next_mode = pmc_pkg::PMC_STANDBY;
      else if (rst_evt)
         next_mode = pmc_pkg::PMC_RESET;
      else if (rst_rel)
         next_mode = pmc_pkg::PMC_STANDBY;
      else if (en_evt)
         next_mode = pmc_pkg::PMC_DISABLE;
      else if (en_rel || fault_evt)
         next_mode = pmc_pkg::PMC_STANDBY;
      else
      begin
         case (mode)
            pmc_pkg::PMC_STANDBY:
               if (cmd_normal || autonomous_i)
                  next_mode = pmc_pkg::PMC_NORMAL;
            pmc_pkg::PMC_NORMAL:
               if (cmd_sreq)
                  next_mode = pmc_pkg::PMC_SLEEP_REQ;
               else if (quiet && (pd_expired || code_expired))
                  next_mode = pmc_pkg::PMC_SLEEP_REQ;
            pmc_pkg::PMC_SLEEP_REQ:
               if (back_to_normal)
                  next_mode = pmc_pkg::PMC_NORMAL;
               else if (!sleep_wake_code_disable_i && sleep_code_received_i && !req_expired)
                  next_mode = pmc_pkg::PMC_SILENT;
               else if (req_expired)
                  next_mode = sleep_wake_code_disable_i ? pmc_pkg::PMC_SLEEP
                     : pmc_pkg::PMC_NORMAL;
            pmc_pkg::PMC_SILENT:
               if (!line_activity_i)
                  next_mode = pmc_pkg::PMC_SLEEP;
               else if (req_expired)
                  next_mode = pmc_pkg::PMC_NORMAL;
            pmc_pkg::PMC_SLEEP:
               if (cmd_standby || wake_event_flag_i)
                  next_mode = pmc_pkg::PMC_STANDBY;
            default:
               next_mode = mode;
         endcase
      end
   end

   // per-mode block enables, registered below
   logic blk_mii_active;
   logic blk_rx_low;
   logic blk_pulldown;
   logic blk_xtal;
   logic blk_ldo;
   logic blk_inh;

   pmc_block_ctrl u_blocks (
      .mode_i(next_mode),
      .clk_hold_i(clk_hold_i),
      .clk_mode_i(clk_mode_i),
      .core_regulator_select_i(core_regulator_select_i),
      .disable_inhibit_behavior_i(disable_inhibit_behavior_i),
      .mii_active_o(blk_mii_active),
      .mii_rx_force_low_o(blk_rx_low),
      .mii_pulldown_o(blk_pulldown),
      .crystal_enable_o(blk_xtal),
      .internal_ldo_enable_o(blk_ldo),
      .inhibit_o(blk_inh)
   );

   wire next_lps = is_mode(next_mode, pmc_pkg::PMC_SLEEP_REQ) && settled
      && (!sleep_ack_i || ack_expired);

   // outputs follow next mode so they change in the transition cycle
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         mode <= pmc_pkg::PMC_STANDBY;
         prev_mode <= pmc_pkg::PMC_STANDBY;
         mgmt_grant_o <= 1'b0;
         mii_active_o <= 1'b0;
         mii_rx_force_low_o <= 1'b1;
         mii_pulldown_o <= 1'b1;
         crystal_enable_o <= 1'b0;
         internal_ldo_enable_o <= 1'b0;
         regulator_inhibit_out_o <= 1'b1;
         sleep_request_code_o <= 1'b0;
         regs_default_o <= 1'b0;
      end
      else if (ce_i)
      begin
         // mode register updates with the transition
         mode <= next_mode;
         prev_mode <= mode;
         mgmt_grant_o <= mgmt_valid_i && access_ok;
         mii_active_o <= blk_mii_active;
         mii_rx_force_low_o <= blk_rx_low;
         mii_pulldown_o <= blk_pulldown;
         crystal_enable_o <= blk_xtal;
         internal_ldo_enable_o <= blk_ldo;
         regulator_inhibit_out_o <= blk_inh;
         sleep_request_code_o <= next_lps;
         regs_default_o <= is_mode(next_mode, pmc_pkg::PMC_RESET);
      end
   end

   assign power_mode_o = mode;

   io_uv_prio_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      ce_i && power_good_i && io_undervoltage_i && !in_sleep |=> mode == pmc_pkg::PMC_STANDBY)
      else $error("io undervoltage did not force standby");

   rst_pin_entry_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      ce_i && power_good_i && !io_undervoltage_i && rst_held && !in_sleep && !in_off
      |=> mode == pmc_pkg::PMC_RESET)
      else $error("held reset pin did not enter reset");

   sreq_cmd_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      ce_i && low_ok && in_normal && cmd_sreq |=> mode == pmc_pkg::PMC_SLEEP_REQ)
      else $error("sleep request command ignored");

   normal_cmd_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      ce_i && low_ok && in_sreq && cmd_normal && back_allowed |=> in_normal)
      else $error("normal command ignored in sleep request");

   activity_back_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      ce_i && low_ok && in_sreq && activity && !sleep_ack_i |=> in_normal)
      else $error("activity did not return to normal");

   silent_timeout_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      ce_i && low_ok && in_silent && line_activity_i && req_expired |=> in_normal)
      else $error("silent did not time out to normal");

   silent_sleep_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      ce_i && low_ok && in_silent && !line_activity_i |=> in_sleep && !regulator_inhibit_out_o)
      else $error("silent did not reach sleep");

   // codes disabled, timeout goes to sleep
   direct_sleep_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      ce_i && low_ok && in_sreq && !back_to_normal && req_expired && sleep_wake_code_disable_i
      |=> in_sleep)
      else $error("sleep request did not go to sleep");

   mii_standby_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      ce_i && $changed(mode) && mode == pmc_pkg::PMC_STANDBY
      |-> mii_rx_force_low_o && mii_pulldown_o && !mii_active_o)
      else $error("standby mii levels wrong");

   // crystal off in sleep without hold
   xtal_sleep_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      ce_i && $changed(mode) && in_sleep && !clk_hold_i |-> !crystal_enable_o)
      else $error("crystal running in sleep");
endmodule

//--- tb/pmc_far_end.sv
// far-end phy model answering sleep requests on the line
`timescale 1ns/100ps
module pmc_far_end (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic hold_line_i,
   input wire logic sleep_request_code_i,
   output logic sleep_code_received_o,
   output logic sleep_code_active_o,
   output logic line_activity_o
);
   logic [1:0] seen;
   logic [1:0] quiet;
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
         seen <= 2'h0;
      else if (sleep_request_code_i && seen != 2'h3)
         seen <= seen + 2'h1;
      if (rst_i || !sleep_code_received_o)
         quiet <= 2'h0;
      else if (quiet != 2'h3)
         quiet <= quiet + 2'h1;
   end
   assign sleep_code_received_o = start_i || seen == 2'h3;
   assign sleep_code_active_o = sleep_code_received_o;
   assign line_activity_o = hold_line_i || quiet != 2'h3;
endmodule

//--- tb/pmc_mode_ctrl_bench.sv
// self-checking bench for the phy power mode controller
`timescale 1ns/100ps
module pmc_mode_ctrl_bench;
   // short timeouts keep the run brief
   localparam int REQ = 8;
   localparam int ACK = 4;
   localparam int APD = 12;
   localparam int RDC = 3;
   localparam logic [4:0] MREG = pmc_pkg::PMC_MODE_REG_ADDR;
   typedef struct packed {
      logic hold;
      logic [1:0] cm;
      logic sel;
      logic xtal;
   } pmc_row_t;
   pmc_row_t rows [5] = '{'{1'b0, 2'h0, 1'b0, 1'b0}, '{1'b1, 2'h0, 1'b1, 1'b1},
      '{1'b1, 2'h1, 1'b0, 1'b1}, '{1'b1, 2'h2, 1'b1, 1'b0}, '{1'b1, 2'h3, 1'b0, 1'b0}};
   logic clock_i, rst_i, ce_i, power_good_i, io_undervoltage_i, rst_pin_n_i, en_pin_i;
   logic core_fault_i, mgmt_valid_i, mgmt_write_i, autonomous_i, clk_hold_i;
   logic [4:0] mgmt_addr_i;
   logic [3:0] mgmt_wdata_i, power_mode_o;
   logic [1:0] clk_mode_i;
   logic core_regulator_select_i, disable_inhibit_behavior_i, auto_powerdown_enable_i;
   logic sleep_wake_code_disable_i, forward_to_line_enable_i, wake_event_flag_i;
   logic wake_request_code_i, sleep_ack_i, pcs_rx_dv_i, tx_en_i, rcv, act, line, start, hold;
   logic mgmt_grant_o, mii_active_o, mii_rx_force_low_o, mii_pulldown_o, crystal_enable_o;
   logic internal_ldo_enable_o, regulator_inhibit_out_o, sleep_request_code_o, regs_default_o;
   int miscompares = 0;
   int tests_run = 0;
   int cyc = 0;
   int n;

   pmc_mode_ctrl #(.REQ_SLEEP_CYC(REQ), .ACK_SLEEP_CYC(ACK), .AUTO_PD_CYC(APD),
      .RST_DET_CYC(RDC)) pmc_mode_ctrl_inst (.clock_i, .rst_i, .ce_i, .power_good_i,
      .io_undervoltage_i, .rst_pin_n_i, .en_pin_i, .core_fault_i, .mgmt_valid_i,
      .mgmt_write_i, .mgmt_addr_i, .mgmt_wdata_i, .autonomous_i, .clk_hold_i, .clk_mode_i,
      .core_regulator_select_i, .disable_inhibit_behavior_i, .auto_powerdown_enable_i,
      .sleep_wake_code_disable_i, .sleep_code_received_i(rcv), .sleep_code_active_i(act),
      .forward_to_line_enable_i, .wake_event_flag_i, .wake_request_code_i, .sleep_ack_i,
      .pcs_rx_dv_i, .tx_en_i, .line_activity_i(line), .power_mode_o, .mgmt_grant_o,
      .mii_active_o, .mii_rx_force_low_o, .mii_pulldown_o, .crystal_enable_o,
      .internal_ldo_enable_o, .regulator_inhibit_out_o, .sleep_request_code_o,
      .regs_default_o);

   pmc_far_end pmc_far_end_inst (.clock_i, .rst_i, .start_i(start), .hold_line_i(hold),
      .sleep_request_code_i(sleep_request_code_o), .sleep_code_received_o(rcv),
      .sleep_code_active_o(act), .line_activity_o(line));

   initial
   begin
      clock_i = 1'b0;
      forever #25 clock_i = ~clock_i;
   end

   task automatic summarize();
      if (miscompares == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // ceiling well above the few hundred cycles the tests need
   always @(posedge clock_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         miscompares++;
         $display("Error at %0t: run did not finish", $time);
         summarize();
      end
   end

   task automatic tick(input int k);
      repeat (k) @(negedge clock_i);
   endtask

   task automatic check_mode(input logic [3:0] exp);
      tests_run++;
      if (power_mode_o !== exp)
      begin
         miscompares++;
         $display("Error at %0t: mode %h, expected %h", $time, power_mode_o, exp);
      end
   endtask

   task automatic check_bit(input logic got, input logic exp);
      tests_run++;
      if (got !== exp)
      begin
         miscompares++;
         $display("Error at %0t: output bit %b, expected %b", $time, got, exp);
      end
   endtask

   task automatic check_count(input int got, input int exp);
      tests_run++;
      if (got != exp)
      begin
         miscompares++;
         $display("Error at %0t: %0d cycles, expected %0d", $time, got, exp);
      end
   endtask

   // bounded wait, leaves the cycle count in n
   task automatic wait_mode(input logic [3:0] exp, input int lim);
      n = 0;
      while (power_mode_o !== exp && n < lim)
      begin
         tick(1);
         n++;
      end
      check_mode(exp);
   endtask

   task automatic mwrite(input logic [4:0] a, input logic [3:0] d, input logic g);
      mgmt_valid_i = 1'b1;
      mgmt_write_i = 1'b1;
      mgmt_addr_i = a;
      mgmt_wdata_i = d;
      tick(1);
      mgmt_valid_i = 1'b0;
      mgmt_write_i = 1'b0;
      check_bit(mgmt_grant_o, g);
   endtask

   task automatic start_run();
      {ce_i, power_good_i, rst_pin_n_i, en_pin_i, sleep_wake_code_disable_i} = 5'h1f;
      {io_undervoltage_i, core_fault_i, mgmt_valid_i, mgmt_write_i, autonomous_i} = 5'h00;
      {clk_hold_i, clk_mode_i, core_regulator_select_i, disable_inhibit_behavior_i} = 5'h00;
      {auto_powerdown_enable_i, forward_to_line_enable_i, wake_event_flag_i} = 3'h0;
      {wake_request_code_i, sleep_ack_i, pcs_rx_dv_i, tx_en_i, start, hold} = 6'h00;
      mgmt_addr_i = 5'h00;
      mgmt_wdata_i = 4'h0;
      rst_i = 1'b1;
      tick(5);
      rst_i = 1'b0;
   endtask

   task automatic go_normal();
      autonomous_i = 1'b1;
      wait_mode(pmc_pkg::PMC_NORMAL, 3);
      autonomous_i = 1'b0;
   endtask

   initial
   begin
      start_run();
      foreach (rows[i])
      begin
         start_run();
         clk_hold_i = rows[i].hold;
         clk_mode_i = rows[i].cm;
         core_regulator_select_i = rows[i].sel;
         go_normal();
         check_bit(internal_ldo_enable_o, ~rows[i].sel);
         mwrite(MREG, 4'hb, 1'b1);
         check_mode(pmc_pkg::PMC_SLEEP_REQ);
         tick(2);
         check_bit(sleep_request_code_o, 1'b1);
         wait_mode(pmc_pkg::PMC_SLEEP, REQ + 2);
         check_count(n, REQ);
         check_bit(crystal_enable_o, rows[i].xtal);
         check_bit(internal_ldo_enable_o, 1'b0);
         check_bit(regulator_inhibit_out_o, 1'b0);
         mwrite(5'h00, 4'hc, 1'b0);
         tick(1);
         mwrite(MREG, 4'hc, 1'b1);
         check_mode(pmc_pkg::PMC_STANDBY);
         check_bit(mii_rx_force_low_o, 1'b1);
         check_bit(mii_pulldown_o, 1'b1);
         check_bit(mii_active_o, 1'b0);
      end
      // command, wake code, forwarded wake, data activity
      start_run();
      go_normal();
      for (int k = 0; k < 4; k++)
      begin
         mwrite(MREG, 4'hb, 1'b1);
         wake_request_code_i = (k == 1);
         forward_to_line_enable_i = (k == 2);
         wake_event_flag_i = (k == 2);
         tx_en_i = (k == 3);
         if (k == 0)
         begin
            tick(1);
            mwrite(MREG, 4'h3, 1'b1);
         end
         wait_mode(pmc_pkg::PMC_NORMAL, 2);
         {wake_request_code_i, forward_to_line_enable_i, wake_event_flag_i, tx_en_i} = 4'h0;
      end
      sleep_ack_i = 1'b1;
      mwrite(MREG, 4'hb, 1'b1);
      wake_request_code_i = 1'b1;
      wait_mode(pmc_pkg::PMC_NORMAL, 2);
      wake_request_code_i = 1'b0;
      mwrite(MREG, 4'hb, 1'b1);
      tick(ACK + 2);
      wake_request_code_i = 1'b1;
      tick(1);
      check_bit(power_mode_o == pmc_pkg::PMC_NORMAL, 1'b0);
      // confirmed request passes silent into sleep
      start_run();
      sleep_wake_code_disable_i = 1'b0;
      go_normal();
      mwrite(MREG, 4'hb, 1'b1);
      wait_mode(pmc_pkg::PMC_SILENT, REQ);
      wait_mode(pmc_pkg::PMC_SLEEP, 6);
      // remote request blocked by traffic, channel kept busy
      start_run();
      sleep_wake_code_disable_i = 1'b0;
      hold = 1'b1;
      go_normal();
      tx_en_i = 1'b1;
      start = 1'b1;
      tick(REQ + 4);
      check_mode(pmc_pkg::PMC_NORMAL);
      tx_en_i = 1'b0;
      wait_mode(pmc_pkg::PMC_SLEEP_REQ, REQ + 3);
      wait_mode(pmc_pkg::PMC_SILENT, 3);
      wait_mode(pmc_pkg::PMC_NORMAL, REQ + 3);
      start_run();
      auto_powerdown_enable_i = 1'b1;
      go_normal();
      pcs_rx_dv_i = 1'b1;
      tick(APD + 4);
      check_mode(pmc_pkg::PMC_NORMAL);
      pcs_rx_dv_i = 1'b0;
      wait_mode(pmc_pkg::PMC_SLEEP_REQ, APD + 3);
      // priority of pins and supplies
      start_run();
      go_normal();
      ce_i = 1'b0;
      core_fault_i = 1'b1;
      tick(3);
      check_mode(pmc_pkg::PMC_NORMAL);
      ce_i = 1'b1;
      wait_mode(pmc_pkg::PMC_STANDBY, 2);
      core_fault_i = 1'b0;
      rst_pin_n_i = 1'b0;
      en_pin_i = 1'b0;
      wait_mode(pmc_pkg::PMC_RESET, RDC + 3);
      check_bit(regs_default_o, 1'b1);
      rst_pin_n_i = 1'b1;
      wait_mode(pmc_pkg::PMC_DISABLE, 3);
      check_bit(regulator_inhibit_out_o, 1'b0);
      disable_inhibit_behavior_i = 1'b1;
      tick(2);
      check_bit(regulator_inhibit_out_o, 1'b1);
      io_undervoltage_i = 1'b1;
      wait_mode(pmc_pkg::PMC_STANDBY, 2);
      power_good_i = 1'b0;
      wait_mode(pmc_pkg::PMC_POWER_OFF, 2);
      // reset in mid-run
      start_run();
      go_normal();
      rst_i = 1'b1;
      tick(1);
      rst_i = 1'b0;
      check_mode(pmc_pkg::PMC_STANDBY);
      check_bit(regulator_inhibit_out_o, 1'b1);
      check_bit(regs_default_o, 1'b0);
      tick(2);
      check_mode(pmc_pkg::PMC_STANDBY);
      summarize();
   end
endmodule
